/* File: rtl/acoustic_detect_pkg.sv */
/*
  Shared constants, types and state record for the acoustic activity detect
  control block. Assumes a single 25 MHz system clock and a synchronous reset.
*/
package acoustic_detect_pkg;

  // System clock and pdm clock classification
  localparam int CLK_MHZ       = 25;
  localparam int CLK_OFF_US    = 40;
  localparam int CLK_OFF_CYC   = CLK_OFF_US * CLK_MHZ;
  localparam int LP_CLK_KHZ    = 768;
  localparam int LP_PER_CYC    = (CLK_MHZ * 1000) / LP_CLK_KHZ;
  localparam int LP_PER_TOL    = 4;
  localparam int INT_CLK_KHZ   = 768;
  localparam int INT_DIV_CYC   = (CLK_MHZ * 1000) / INT_CLK_KHZ;

  // One-wire symbol timing, in pdm clock cycles or pilot units
  localparam int PILOT_MIN      = 8;
  localparam int PILOT_MAX      = 20;
  localparam int STOP_HIGH_CLK  = 128;
  localparam int STOP_LOW_UNITS = 8;
  localparam int FRAME_BITS     = 24;

  localparam logic [7:0] DEV_ADDR_BYTE = 8'ha6;
  localparam int         UNLOCK_LEN    = 5;
  localparam logic [7:0] UNLOCK_A0     = 8'h5c;
  localparam logic [7:0] UNLOCK_A1     = 8'h3e;
  localparam logic [7:0] UNLOCK_A2     = 8'h6f;
  localparam logic [7:0] UNLOCK_A3     = 8'h3b;
  localparam logic [7:0] UNLOCK_A4     = 8'h4c;

  // Device registers written over the one-wire link
  localparam logic [7:0] REG_EN   = 8'h29;
  localparam logic [7:0] REG_ALPF = 8'h35;
  localparam logic [7:0] REG_ATH  = 8'h36;
  localparam logic [7:0] REG_DABS = 8'h2e;
  localparam logic [7:0] REG_DREL = 8'h2f;
  localparam logic [7:0] REG_DDUR = 8'h30;
  localparam int         EN_D1    = 0;
  localparam int         EN_D2    = 1;
  localparam int         EN_A     = 3;
  localparam logic [3:0] EN_MASK  = 4'hb;
  localparam logic [3:0] EN_RST   = 4'h0;
  localparam logic [2:0] ALPF_RST = 3'h0;
  localparam logic [3:0] ATH_RST  = 4'h0;
  localparam logic [7:0] DABS_RST = 8'h20;
  localparam logic [7:0] DREL_RST = 8'h04;
  localparam logic [7:0] DDUR_RST = 8'h02;

  // AXI4-Lite map
  localparam logic [4:0] A_CTRL    = 5'h00;
  localparam logic [4:0] A_STATUS  = 5'h04;
  localparam logic [4:0] A_ACFG    = 5'h08;
  localparam logic [4:0] A_DCFG    = 5'h0c;
  localparam logic [4:0] A_FRAMES  = 5'h10;
  localparam int         CTRL_PWR  = 0;
  localparam int         CTRL_LINK = 1;
  localparam logic       LINK_RST  = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DEC  = 2'b11;

  // Synchroniser lanes
  localparam int SI_CLK   = 0;
  localparam int SI_LINE  = 1;
  localparam int SI_ABOVE = 2;
  localparam int SI_BELOW = 3;
  localparam int SI_MOD   = 4;
  localparam int SI_W     = 5;

  typedef enum logic [3:0] {
    LS_IDLE  = 4'b0001,
    LS_PILOT = 4'b0010,
    LS_SPACE = 4'b0100,
    LS_BIT   = 4'b1000
  } link_state_t;

  typedef struct packed {
    link_state_t ls;
    logic [7:0]  cnt;
    logic [7:0]  pilot;
    logic [4:0]  bits;
    logic [23:0] shreg;
    logic [2:0]  unlock_idx;
    logic        unlocked;
    logic [3:0]  en;
    logic [2:0]  alpf;
    logic [3:0]  ath;
    logic [7:0]  dabs;
    logic [7:0]  drel;
    logic [7:0]  ddur;
    logic [10:0] per;
    logic [10:0] last_per;
    logic        clk_off;
    logic        clk_lp;
    logic [5:0]  div;
    logic [5:0]  win;
    logic [6:0]  ones;
    logic [6:0]  level;
    logic [6:0]  avg;
    logic [7:0]  run;
    logic        dwake;
    logic        wake;
    logic        pdm_out;
    logic [15:0] good;
    logic [15:0] bad;
    logic        link_en;
    logic        aw_got;
    logic [4:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

endpackage : acoustic_detect_pkg

/* File: rtl/pin_sync.sv */
/*
  Two-flop synchronisers with edge detection for pins outside the clock domain.
  Assumes inputs are asynchronous levels; the third stage feeds edge detection.
*/
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
  assign fall  = ~s2_q & s3_q;

endmodule : pin_sync

/* File: rtl/acoustic_detect_ctrl.sv */
/*
  Acoustic activity detect control: one-wire config receiver on the threshold
  select line, unlock tracking, pdm clock mode sensing, detect modes and wake.
  Assumes pins are asynchronous to aclk and software uses AXI4-Lite.
*/
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
module acoustic_detect_ctrl
  import acoustic_detect_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pdm_clk,
  input  wire logic        threshold_select_line,
  input  wire logic        analog_above_threshold,
  input  wire logic        analog_below_cutoff,
  input  wire logic        modulator_bit,
  output logic [2:0]       analog_lpf_sel,
  output logic [3:0]       analog_threshold_sel,
  output logic             pdm_data_out,
  output logic             pdm_data_oe,
  output logic             wake
);

  state_t          q;
  state_t          d;
  logic [SI_W-1:0] sy_level;
  logic [SI_W-1:0] sy_rise;
  logic [SI_W-1:0] sy_fall;
  logic            clk_rise;
  logic [9:0]      c10;
  logic [9:0]      p10;
  logic            commit;
  logic            frame_bad;
  logic            wr_en;
  logic [7:0]      wr_addr;
  logic [7:0]      wr_data;
  logic            a_act;
  logic            d1_act;
  logic            d2_act;
  logic            samp;
  logic            tick;
  logic [6:0]      lvl;
  logic            cond;
  logic [7:0]      nrun;
  logic            pwr_clear;
  logic [4:0]      raddr;

  function automatic logic [7:0] unlock_addr(input logic [2:0] idx);
    case (idx)
      3'd0:    unlock_addr = UNLOCK_A0;
      3'd1:    unlock_addr = UNLOCK_A1;
      3'd2:    unlock_addr = UNLOCK_A2;
      3'd3:    unlock_addr = UNLOCK_A3;
      default: unlock_addr = UNLOCK_A4;
    endcase
  endfunction : unlock_addr

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hff) ? v : v + 8'h01;
  endfunction : sat_inc

  pin_sync #(
    .W(SI_W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .async_in({modulator_bit, analog_below_cutoff, analog_above_threshold,
               threshold_select_line, pdm_clk}),
    .level   (sy_level),
    .rise    (sy_rise),
    .fall    (sy_fall)
  );

  assign clk_rise = sy_rise[SI_CLK];

  always_comb begin
    d         = q;
    c10       = {2'b00, q.cnt};
    p10       = {2'b00, q.pilot};
    commit    = 1'b0;
    frame_bad = 1'b0;
    wr_en     = 1'b0;
    wr_addr   = q.shreg[15:8];
    wr_data   = q.shreg[7:0];
    tick      = 1'b0;
    samp      = 1'b0;
    lvl       = q.level;
    cond      = 1'b0;
    nrun      = 8'h00;
    pwr_clear = 1'b0;
    raddr     = 5'h00;

    // Clock rate sensing from pdm clock edges
    if (clk_rise) begin
      d.last_per = q.per;
      d.per      = 11'h000;
      d.clk_off  = 1'b0;
      d.clk_lp   = (q.per >= 11'(LP_PER_CYC - LP_PER_TOL))
                   && (q.per <= 11'(LP_PER_CYC + LP_PER_TOL));
    end else if (q.per < 11'(CLK_OFF_CYC)) begin
      d.per = q.per + 11'h001;
    end else begin
      d.clk_off = 1'b1;
      d.clk_lp  = 1'b0;
    end

    // One-wire receiver, counted in pdm clock cycles
    if (clk_rise) begin
      d.cnt = sat_inc(q.cnt);
    end
    case (q.ls)
      LS_IDLE: begin
        if (sy_rise[SI_LINE]) begin
          d.cnt = 8'h00;
          d.ls  = LS_PILOT;
        end
      end
      LS_PILOT: begin
        if (sy_fall[SI_LINE]) begin
          d.cnt = 8'h00;
          if (q.cnt >= 8'(PILOT_MIN) && q.cnt <= 8'(PILOT_MAX)) begin
            d.pilot = q.cnt;
            d.bits  = 5'd0;
            d.ls    = LS_SPACE;
          end else begin
            d.ls = LS_IDLE;
          end
        end
      end
      LS_SPACE: begin
        if (q.bits == 5'(FRAME_BITS) && c10 > 10'(STOP_LOW_UNITS) * p10) begin
          commit = 1'b1;
        end else if (q.bits != 5'(FRAME_BITS) && c10 > (p10 << 1)) begin
          frame_bad = 1'b1;
        end else if (sy_rise[SI_LINE]) begin
          d.cnt = 8'h00;
          if (c10 + 10'd1 >= p10 && c10 <= (p10 << 1)) begin
            d.ls = LS_BIT;
          end else begin
            frame_bad = 1'b1;
          end
        end
      end
      LS_BIT: begin
        if (q.bits == 5'(FRAME_BITS) && q.cnt > 8'(STOP_HIGH_CLK)) begin
          commit = 1'b1;
        end else if (sy_fall[SI_LINE]) begin
          d.cnt = 8'h00;
          d.ls  = LS_SPACE;
          if (q.bits == 5'(FRAME_BITS)) begin
            frame_bad = 1'b1;
          end else if ((c10 << 1) <= 10'd3 * p10) begin
            d.shreg = {q.shreg[22:0], 1'b0};
            d.bits  = q.bits + 5'd1;
          end else if (c10 >= (p10 << 1) && (c10 << 1) <= 10'd7 * p10) begin
            d.shreg = {q.shreg[22:0], 1'b1};
            d.bits  = q.bits + 5'd1;
          end else begin
            frame_bad = 1'b1;
          end
        end
      end
      default: begin
        d.ls = LS_IDLE;
      end
    endcase

    // Stopped clock or disabled link aborts frame
    if (!q.link_en || q.clk_off) begin
      d.ls = LS_IDLE;
    end

    if (commit) begin
      d.ls = LS_IDLE;
      if (q.shreg[23:16] == DEV_ADDR_BYTE) begin
        wr_en  = 1'b1;
        d.good = q.good + 16'h0001;
      end else begin
        d.bad = q.bad + 16'h0001;
      end
    end else if (frame_bad) begin
      d.ls  = LS_IDLE;
      d.bad = q.bad + 16'h0001;
    end

    if (wr_en && !q.unlocked) begin
      if (wr_data == 8'h00 && wr_addr == unlock_addr(q.unlock_idx)) begin
        d.unlock_idx = q.unlock_idx + 3'd1;
        d.unlocked   = (q.unlock_idx == 3'(UNLOCK_LEN - 1));
      end else if (wr_data == 8'h00 && wr_addr == UNLOCK_A0) begin
        d.unlock_idx = 3'd1;
      end else begin
        d.unlock_idx = 3'd0;
      end
    end

    if (wr_en && q.unlocked) begin
      case (wr_addr)
        REG_EN:   d.en   = wr_data[3:0] & EN_MASK;
        REG_ALPF: d.alpf = wr_data[2:0];
        REG_ATH:  d.ath  = wr_data[3:0];
        REG_DABS: d.dabs = wr_data;
        REG_DREL: d.drel = wr_data;
        REG_DDUR: d.ddur = wr_data;
        default:  d.en   = q.en;
      endcase
    end

    // Analog needs enable and clock off
    a_act  = q.en[EN_A] && q.clk_off;
    d1_act = q.en[EN_D1] && q.clk_lp;
    d2_act = q.en[EN_D2] && q.clk_off;

    if (q.div == 6'(INT_DIV_CYC - 1)) begin
      d.div = 6'd0;
      tick  = 1'b1;
    end else begin
      d.div = q.div + 6'd1;
    end

    samp = (d1_act && clk_rise) || (d2_act && tick);
    if (!(d1_act || d2_act)) begin
      d.win   = 6'd0;
      d.ones  = 7'd0;
      d.run   = 8'h00;
      d.dwake = 1'b0;
    end else if (samp) begin
      lvl    = q.ones + {6'd0, sy_level[SI_MOD]};
      d.win  = q.win + 6'd1;
      d.ones = lvl;
      if (q.win == 6'h3f) begin
        d.ones  = 7'd0;
        d.level = lvl;
        d.avg   = 7'(({3'b000, q.avg} * 10'd7 + {3'b000, lvl}) >> 3);
        cond    = ({1'b0, lvl} > q.dabs)
                  && ({2'b00, lvl} > {2'b00, q.avg} + {1'b0, q.drel});
        nrun    = cond ? sat_inc(q.run) : 8'h00;
        d.run   = nrun;
        d.dwake = cond && (nrun >= q.ddur);
      end
    end

    d.wake = (a_act && sy_level[SI_ABOVE] && sy_level[SI_BELOW])
             || ((d1_act || d2_act) && q.dwake);

    if (clk_rise) begin
      d.pdm_out = sy_level[SI_MOD];
    end

    // AXI4-Lite write path
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      case (q.aw_addr)
        A_CTRL: begin
          if (q.wstrb[0]) begin
            pwr_clear = q.wdata[CTRL_PWR];
            d.link_en = q.wdata[CTRL_LINK];
          end
        end
        A_STATUS, A_ACFG, A_DCFG, A_FRAMES: d.bresp = RESP_OKAY;
        default: d.bresp = RESP_DEC;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Power cycle drops unlock and enables
    if (pwr_clear) begin
      d.unlocked   = 1'b0;
      d.unlock_idx = 3'd0;
      d.en         = EN_RST;
    end

    // AXI4-Lite read path
    if (s_axi_arvalid && s_axi_arready) begin
      raddr   = s_axi_araddr;
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      case (raddr)
        A_CTRL:   d.rdata = {30'h0, q.link_en, 1'b0};
        A_STATUS: d.rdata = {20'h0, q.last_per[10:0] == 11'h000, d1_act, d2_act, a_act,
                             q.unlocked, q.clk_lp, q.clk_off, q.wake, 4'h0};
        A_ACFG:   d.rdata = {21'h0, q.alpf, q.ath, q.en};
        A_DCFG:   d.rdata = {8'h0, q.ddur, q.drel, q.dabs};
        A_FRAMES: d.rdata = {q.bad, q.good};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = RESP_DEC;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.ls       <= LS_IDLE;
      q.en       <= EN_RST;
      q.alpf     <= ALPF_RST;
      q.ath      <= ATH_RST;
      q.dabs     <= DABS_RST;
      q.drel     <= DREL_RST;
      q.ddur     <= DDUR_RST;
      q.clk_off  <= 1'b1;
      q.link_en  <= LINK_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready        = !q.aw_got && !q.bvalid;
  assign s_axi_wready         = !q.w_got && !q.bvalid;
  assign s_axi_bvalid         = q.bvalid;
  assign s_axi_bresp          = q.bresp;
  assign s_axi_arready        = !q.rvalid;
  assign s_axi_rvalid         = q.rvalid;
  assign s_axi_rdata          = q.rdata;
  assign s_axi_rresp          = q.rresp;
  assign analog_lpf_sel       = q.alpf;
  assign analog_threshold_sel = q.ath;
  assign pdm_data_out         = q.pdm_out;
  assign pdm_data_oe          = !q.clk_off;
  assign wake                 = q.wake;

endmodule : acoustic_detect_ctrl

/* File: sim/host_link_model.sv */
/*
  Host side model: drives the pdm clock and the one-wire config line.
  Assumes the bench calls its tasks hierarchically and sets clk_run.
*/
module host_link_model (
  output logic pdm_clk,
  output logic threshold_select_line
);
  timeunit 1ns;
  timeprecision 1ps;

  bit clk_run = 1'b1;

  initial begin
    pdm_clk = 1'b0;
    threshold_select_line = 1'b0;
    #7;
    forever begin
      #160;
      pdm_clk = clk_run;
      #160;
      pdm_clk = 1'b0;
    end
  end

  task automatic hold_level(input logic v, input int n);
    @(negedge pdm_clk);
    threshold_select_line = v;
    repeat (n) @(posedge pdm_clk);
  endtask : hold_level

  task automatic send_frame(input logic [23:0] f, input int p, input int zero,
                            input int one, input int sp, input bit stop_high);
    hold_level(1'b1, p);
    for (int i = 23; i >= 0; i--) begin
      hold_level(1'b0, sp);
      hold_level(1'b1, f[i] ? one : zero);
    end
    if (stop_high) begin
      hold_level(1'b0, sp);
      hold_level(1'b1, 131);
      hold_level(1'b0, 4);
    end else begin
      hold_level(1'b0, 8 * p + 2);
    end
  endtask : send_frame
endmodule : host_link_model

/* File: sim/acoustic_detect_ctrl_assertions.sv */
/*
  Concurrent checks on the detect control block's ports.
  Assumes binding to acoustic_detect_ctrl; pins are watched raw.
*/
module acoustic_detect_ctrl_assertions (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       pdm_clk,
  input wire logic       threshold_select_line,
  input wire logic [2:0] analog_lpf_sel,
  input wire logic [3:0] analog_threshold_sel,
  input wire logic       pdm_data_out,
  input wire logic       pdm_data_oe,
  input wire logic       wake
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk_q, line_q, rise;
  logic [10:0] idle_q;
  logic [3:0]  since_q;
  logic [7:0]  per_q, lastper_q, run_q, lrise_q;

  assign rise = pdm_clk && !pclk_q;

  // Pin activity counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_q    <= 1'b0;
      line_q    <= 1'b0;
      idle_q    <= 11'h0;
      since_q   <= 4'hf;
      per_q     <= 8'hff;
      lastper_q <= 8'hff;
      run_q     <= 8'h0;
      lrise_q   <= 8'h0;
    end else begin
      pclk_q  <= pdm_clk;
      line_q  <= threshold_select_line;
      idle_q  <= (pdm_clk != pclk_q) ? 11'h0 : idle_q + {10'h0, idle_q != 11'h7ff};
      since_q <= rise ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
      per_q   <= rise ? 8'h0 : per_q + {7'h0, per_q != 8'hff};
      if (rise) begin
        lastper_q <= per_q;
      end
      run_q   <= (idle_q >= 11'h3e8) ? 8'h0 : run_q + {7'h0, run_q != 8'hff};
      if (threshold_select_line != line_q) begin
        lrise_q <= 8'h0;
      end else if (rise && lrise_q != 8'hff) begin
        lrise_q <= lrise_q + 8'h1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_pdm_quiet: assert property (idle_q >= 11'h44c |-> !pdm_data_oe)
    else $error("pdm output driven with clock stopped");
  a_pdm_runs: assert property (run_q == 8'hff && idle_q < 11'h14 |-> pdm_data_oe)
    else $error("pdm output off with clock running");
  a_pdm_out_edge: assert property ($changed(pdm_data_out) |-> since_q <= 4'h8)
    else $error("pdm output moved without a clock rise");
  a_wake_mode: assert property (run_q == 8'hff && lastper_q < 8'h14 &&
    per_q < 8'h14 |-> !wake) else $error("wake high in fast clock mode");
  a_cfg_after_stop: assert property ($changed(analog_lpf_sel) ||
    $changed(analog_threshold_sel) |-> lrise_q >= 8'h3c) else $error("config moved without stop");
  a_reset_clear: assert property (!$past(aresetn) |-> !wake &&
    analog_lpf_sel == 3'h0 && analog_threshold_sel == 4'h0) else $error("state not cleared");
endmodule : acoustic_detect_ctrl_assertions

bind acoustic_detect_ctrl acoustic_detect_ctrl_assertions chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .pdm_clk(pdm_clk), .threshold_select_line(threshold_select_line),
  .analog_lpf_sel(analog_lpf_sel), .analog_threshold_sel(analog_threshold_sel),
  .pdm_data_out(pdm_data_out), .pdm_data_oe(pdm_data_oe), .wake(wake)
);

/* File: sim/tb_acoustic_detect_ctrl.sv */
/*
  Self-checking bench for the detect control block: AXI4-Lite and one-wire writes.
  Assumes host_link_model drives the pdm clock and config line.
*/
module tb_acoustic_detect_ctrl
  import acoustic_detect_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, pdm_clk, threshold_select_line, analog_above_threshold;
  logic        analog_below_cutoff, modulator_bit, pdm_data_out, pdm_data_oe, wake;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, analog_threshold_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  analog_lpf_sel;
  logic [7:0]  ulk [5] = '{UNLOCK_A0, UNLOCK_A1, UNLOCK_A2, UNLOCK_A3, UNLOCK_A4};
  int          failures, samples_checked;

  acoustic_detect_ctrl acoustic_detect_ctrl_inst (.*);
  host_link_model host_link_model_inst (.pdm_clk(pdm_clk),
                                        .threshold_select_line(threshold_select_line));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) modulator_bit <= aresetn ? ~modulator_bit : 1'b0;

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_resp

  task automatic axi_write(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rsp);
    bit tka, tkw, tkb;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      tka = s_axi_awvalid && s_axi_awready;
      tkw = s_axi_wvalid && s_axi_wready;
      tkb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (tka) s_axi_awvalid <= 1'b0;
      if (tkw) s_axi_wvalid <= 1'b0;
      if (tkb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rsp);
    bit tka, tkr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      tka = s_axi_arvalid && s_axi_arready;
      tkr = s_axi_rvalid;
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (tka) s_axi_arvalid <= 1'b0;
      if (tkr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask : axi_read

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
    axi_read(a, d, r);
    check_word(d & m, exp);
  endtask : rd_chk

  task automatic wr_link(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] v);
    host_link_model_inst.send_frame({dev, a, v}, 8, 8, 24, 8, 1'b0);
    repeat (8) @(posedge aclk);
  endtask : wr_link

  task automatic wake_is(input int n, input logic exp);
    repeat (n) @(negedge aclk);
    check_word({31'h0, wake}, {31'h0, exp});
    @(posedge aclk);
  endtask : wake_is

  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (90000) @(posedge aclk);
    failures++;
    finish_test();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {analog_above_threshold, analog_below_cutoff} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(A_ACFG, 32'h7ff, 32'h0);
    rd_chk(A_STATUS, 32'h80, 32'h0);
    axi_read(5'h14, d, r);
    check_resp(r, RESP_DEC);
    wr_link(DEV_ADDR_BYTE, REG_EN, 8'h08);
    rd_chk(A_ACFG, 32'hf, 32'h0);
    foreach (ulk[i]) wr_link(DEV_ADDR_BYTE, ulk[i], 8'h00);
    rd_chk(A_STATUS, 32'h80, 32'h80);
    host_link_model_inst.send_frame({DEV_ADDR_BYTE, REG_ALPF, 8'h05}, 10, 15, 35, 20,
                                    1'b1);
    repeat (8) @(posedge aclk);
    rd_chk(A_ACFG, 32'h700, 32'h500);
    check_word({29'h0, analog_lpf_sel}, 32'h5);
    wr_link(DEV_ADDR_BYTE, REG_ATH, 8'h0c);
    check_word({28'h0, analog_threshold_sel}, 32'hc);
    wr_link(8'ha7, REG_EN, 8'h08);
    rd_chk(A_ACFG, 32'hf, 32'h0);
    wr_link(DEV_ADDR_BYTE, REG_EN, 8'h0f);
    rd_chk(A_ACFG, 32'hf, 32'hb);
    wr_link(DEV_ADDR_BYTE, REG_EN, 8'h08);
    analog_above_threshold <= 1'b1;
    analog_below_cutoff <= 1'b1;
    wake_is(200, 1'b0);
    host_link_model_inst.clk_run = 1'b0;
    wake_is(1200, 1'b1);
    rd_chk(A_STATUS, 32'h7f0, 32'h1b0);
    check_word({31'h0, pdm_data_oe}, 32'h0);
    analog_below_cutoff <= 1'b0;
    wake_is(20, 1'b0);
    analog_below_cutoff <= 1'b1;
    wake_is(20, 1'b1);
    host_link_model_inst.clk_run = 1'b1;
    wake_is(300, 1'b0);
    check_word({31'h0, pdm_data_oe}, 32'h1);
    axi_write(A_CTRL, 32'h3, r);
    check_resp(r, RESP_OKAY);
    rd_chk(A_STATUS, 32'h80, 32'h0);
    rd_chk(A_ACFG, 32'hf, 32'h0);
    wr_link(DEV_ADDR_BYTE, REG_EN, 8'h08);
    rd_chk(A_ACFG, 32'hf, 32'h0);
    axi_write(5'h18, 32'h0, r);
    check_resp(r, RESP_DEC);
    finish_test();
  end
endmodule : tb_acoustic_detect_ctrl
